/* File: src/piopd_top.sv */
`include "piopd_regs.svh"

`default_nettype none

// Functional notes
// - Port 83H write drives upper motor outputs
// - Port 82H write drives lower motor outputs
// - Port logic and disk select need I/O request
// - Reset input clears flops, asserts disk reset
// - Interrupt is open-drain, floats during reset
// - Disk reset low until software writes D0
// - Disk select low for I/O 70H-7FH
// - ROM select on bank, MREQ, T, not U, window
// - Port 81H read returns seven status inputs
// - Status raises interrupt only when enabled
// - Carriage home switch is status bit 5
// - Low motor output energises its coil
// - Host view active high except disk reset
module piopd_top #(
    parameter int MOTOR_WIDTH = `PIOPD_MOTOR_WIDTH,
    parameter int STATUS_WIDTH = `PIOPD_STATUS_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_in,
    input wire logic iorq,
    input wire logic mreq,
    input wire logic m1,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr_lo,
    input wire logic addr_a14,
    input wire logic addr_a15,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic bank_line_high,
    input wire logic rom_qualifier_t,
    input wire logic rom_qualifier_u,
    input wire logic [STATUS_WIDTH-1:0] status_inputs_n,
    output logic [MOTOR_WIDTH-1:0] motor_drive_hi_n,
    output logic [MOTOR_WIDTH-1:0] motor_drive_lo_n,
    output logic disk_unit_select_n,
    output logic rom_select_n,
    output logic disk_unit_reset_n,
    output logic irq_n_out,
    output logic irq_n_oe
);

    // Clear for every internal flip-flop
    logic clear_all;

    // Cycle qualification
    logic io_cycle;
    logic io_write;
    logic io_read;
    piopd_pkg::piopd_cycle_t cycle_kind;
    piopd_pkg::piopd_port_sel_t port_sel;

    // Decoded writes
    logic wr_irq_en;
    logic wr_status;
    logic wr_motor_lo;
    logic wr_motor_hi;

    // Latch contents, host polarity
    logic [MOTOR_WIDTH-1:0] motor_lo_q;
    logic [MOTOR_WIDTH-1:0] motor_hi_q;
    logic [STATUS_WIDTH-1:0] irq_en_q;

    // Status inputs converted to host polarity
    logic [STATUS_WIDTH-1:0] status_active;
    logic carriage_home;
    logic irq_pending;

    // Read path
    logic read_drive;
    logic [7:0] read_mux;

    // Select decode
    logic disk_sel_hit;
    logic rom_sel_hit;

    // Output registers
    logic [7:0] data_out_reg;
    logic data_oe_reg;
    logic [MOTOR_WIDTH-1:0] motor_hi_n_reg;
    logic [MOTOR_WIDTH-1:0] motor_lo_n_reg;
    logic disk_unit_select_n_reg;
    logic rom_select_n_reg;
    logic disk_unit_reset_n_reg;
    logic irq_n_out_reg;
    logic irq_n_oe_reg;

    function automatic piopd_pkg::piopd_port_sel_t decode_port(input logic [7:0] a);
        piopd_pkg::piopd_port_sel_t sel;
        sel = piopd_pkg::PIOPD_SEL_NONE;
        if (a == `PIOPD_PORT_IRQ_EN) begin
            sel = piopd_pkg::PIOPD_SEL_IRQ_EN;
        end else if (a == `PIOPD_PORT_STATUS) begin
            sel = piopd_pkg::PIOPD_SEL_STATUS;
        end else if (a == `PIOPD_PORT_MOTOR_LO) begin
            sel = piopd_pkg::PIOPD_SEL_MOTOR_LO;
        end else if (a == `PIOPD_PORT_MOTOR_HI) begin
            sel = piopd_pkg::PIOPD_SEL_MOTOR_HI;
        end
        return sel;
    endfunction : decode_port

    // Both resets act alike on the internal state
    assign clear_all = rst | reset_in;

    // Interrupt acknowledge (M1 with IORQ) is not a port cycle
    assign io_cycle = iorq & ~m1;
    assign io_write = io_cycle & ~wr_n;
    assign io_read = io_cycle & ~rd_n & wr_n;

    always_comb begin
        if (io_write) begin
            cycle_kind = piopd_pkg::PIOPD_CYC_IO_WRITE;
        end else if (io_read) begin
            cycle_kind = piopd_pkg::PIOPD_CYC_IO_READ;
        end else begin
            cycle_kind = piopd_pkg::PIOPD_CYC_IDLE;
        end
    end

    assign port_sel = decode_port(addr_lo);

    always_comb begin
        wr_irq_en = 1'b0;
        wr_status = 1'b0;
        wr_motor_lo = 1'b0;
        wr_motor_hi = 1'b0;
        if (cycle_kind == piopd_pkg::PIOPD_CYC_IO_WRITE) begin
            case (port_sel)
                piopd_pkg::PIOPD_SEL_IRQ_EN: begin
                    wr_irq_en = 1'b1;
                end
                piopd_pkg::PIOPD_SEL_STATUS: begin
                    wr_status = 1'b1;
                end
                piopd_pkg::PIOPD_SEL_MOTOR_LO: begin
                    wr_motor_lo = 1'b1;
                end
                piopd_pkg::PIOPD_SEL_MOTOR_HI: begin
                    wr_motor_hi = 1'b1;
                end
                default: begin
                    wr_irq_en = 1'b0;
                end
            endcase
        end
    end

    // Port latches keep the host's active-high view
    piopd_latch #(
        .WIDTH(MOTOR_WIDTH),
        .RESET_VALUE(MOTOR_WIDTH'(`PIOPD_MOTOR_RESET))
    ) u_motor_lo (
        .clk(clk),
        .clear(clear_all),
        .load(wr_motor_lo),
        .d(data_in[MOTOR_WIDTH-1:0]),
        .q(motor_lo_q)
    );

    piopd_latch #(
        .WIDTH(MOTOR_WIDTH),
        .RESET_VALUE(MOTOR_WIDTH'(`PIOPD_MOTOR_RESET))
    ) u_motor_hi (
        .clk(clk),
        .clear(clear_all),
        .load(wr_motor_hi),
        .d(data_in[MOTOR_WIDTH-1:0]),
        .q(motor_hi_q)
    );

    piopd_latch #(
        .WIDTH(STATUS_WIDTH),
        .RESET_VALUE(STATUS_WIDTH'(`PIOPD_IRQ_EN_RESET))
    ) u_irq_en (
        .clk(clk),
        .clear(clear_all),
        .load(wr_irq_en),
        .d(data_in[STATUS_WIDTH-1:0]),
        .q(irq_en_q)
    );

    // Motor pins are inverted latch bits: a set bit drives the coil
    always_ff @(posedge clk) begin
        if (clear_all) begin
            motor_hi_n_reg <= '1;
            motor_lo_n_reg <= '1;
        end else begin
            motor_hi_n_reg <= ~motor_hi_q;
            motor_lo_n_reg <= ~motor_lo_q;
        end
    end

    // Disk unit reset: forced low by reset, released only by software
    always_ff @(posedge clk) begin
        if (clear_all) begin
            disk_unit_reset_n_reg <= `PIOPD_DISK_RESET_RST;
        end else if (wr_status) begin
            disk_unit_reset_n_reg <= data_in[`PIOPD_DISK_RESET_BIT];
        end
    end

    // Status inputs as the host sees them
    assign status_active = ~status_inputs_n;
    assign carriage_home = status_active[`PIOPD_CARRIAGE_BIT];
    assign irq_pending = |(status_active & irq_en_q);

    // Read multiplexer; the enable latch is write-only
    always_comb begin
        read_drive = 1'b0;
        read_mux = 8'h00;
        if (cycle_kind == piopd_pkg::PIOPD_CYC_IO_READ) begin
            case (port_sel)
                piopd_pkg::PIOPD_SEL_STATUS: begin
                    read_drive = 1'b1;
                    read_mux = 8'(status_active);
                    read_mux[`PIOPD_CARRIAGE_BIT] = carriage_home;
                end
                piopd_pkg::PIOPD_SEL_MOTOR_LO: begin
                    read_drive = 1'b1;
                    read_mux = 8'(motor_lo_q);
                end
                piopd_pkg::PIOPD_SEL_MOTOR_HI: begin
                    read_drive = 1'b1;
                    read_mux = 8'(motor_hi_q);
                end
                default: begin
                    read_drive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (clear_all) begin
            data_oe_reg <= 1'b0;
            data_out_reg <= 8'h00;
        end else begin
            data_oe_reg <= read_drive;
            data_out_reg <= read_mux;
        end
    end

    // Address decode for the external selects
    always_comb begin
        disk_sel_hit = 1'b0;
        if (!io_cycle) begin
            disk_sel_hit = 1'b0;
        end else if (addr_lo < `PIOPD_DISK_SEL_FIRST) begin
            disk_sel_hit = 1'b0;
        end else if (addr_lo > `PIOPD_DISK_SEL_LAST) begin
            disk_sel_hit = 1'b0;
        end else begin
            disk_sel_hit = 1'b1;
        end
    end

    always_comb begin
        rom_sel_hit = 1'b0;
        if (!(bank_line_high && mreq && rom_qualifier_t)) begin
            rom_sel_hit = 1'b0;
        end else if (rom_qualifier_u) begin
            rom_sel_hit = 1'b0;
        end else if (addr_a15 == `PIOPD_ROM_A15_VALUE && addr_a14 == `PIOPD_ROM_A14_VALUE) begin
            rom_sel_hit = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (clear_all) begin
            disk_unit_select_n_reg <= 1'b1;
        end else begin
            disk_unit_select_n_reg <= ~disk_sel_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (clear_all) begin
            rom_select_n_reg <= 1'b1;
        end else begin
            rom_select_n_reg <= ~rom_sel_hit;
        end
    end

    // Open-drain interrupt: only ever pulls low, released during reset
    always_ff @(posedge clk) begin
        if (clear_all) begin
            irq_n_oe_reg <= 1'b0;
            irq_n_out_reg <= 1'b0;
        end else begin
            irq_n_oe_reg <= irq_pending;
            irq_n_out_reg <= 1'b0;
        end
    end

    assign data_out = data_out_reg;
    assign data_oe = data_oe_reg;
    assign motor_drive_hi_n = motor_hi_n_reg;
    assign motor_drive_lo_n = motor_lo_n_reg;
    assign disk_unit_select_n = disk_unit_select_n_reg;
    assign rom_select_n = rom_select_n_reg;
    assign disk_unit_reset_n = disk_unit_reset_n_reg;
    assign irq_n_out = irq_n_out_reg;
    assign irq_n_oe = irq_n_oe_reg;

endmodule : piopd_top

`default_nettype wire

/* File: src/piopd_regs.svh */
`ifndef PIOPD_REGS_SVH
`define PIOPD_REGS_SVH

// Port addresses on the low address byte
`define PIOPD_PORT_IRQ_EN     8'h80
`define PIOPD_PORT_STATUS     8'h81
`define PIOPD_PORT_MOTOR_LO   8'h82
`define PIOPD_PORT_MOTOR_HI   8'h83

// Disk unit select window on the low address byte
`define PIOPD_DISK_SEL_FIRST  8'h70
`define PIOPD_DISK_SEL_LAST   8'h7F

// ROM window 4000H to 7FFFH: A15 low, A14 high
`define PIOPD_ROM_A15_VALUE   1'h0
`define PIOPD_ROM_A14_VALUE   1'h1

// Field positions
`define PIOPD_DISK_RESET_BIT  0
`define PIOPD_CARRIAGE_BIT    5

// Widths
`define PIOPD_MOTOR_WIDTH     8
`define PIOPD_STATUS_WIDTH    7

// Reset values, as seen from the host
`define PIOPD_MOTOR_RESET     8'h00
`define PIOPD_IRQ_EN_RESET    7'h00
`define PIOPD_DISK_RESET_RST  1'h0

`endif

/* File: src/piopd_pkg.sv */
`default_nettype none

package piopd_pkg;

    typedef enum logic [2:0] {
        PIOPD_SEL_NONE,
        PIOPD_SEL_IRQ_EN,
        PIOPD_SEL_STATUS,
        PIOPD_SEL_MOTOR_LO,
        PIOPD_SEL_MOTOR_HI
    } piopd_port_sel_t;

    typedef enum logic [1:0] {
        PIOPD_CYC_IDLE,
        PIOPD_CYC_IO_READ,
        PIOPD_CYC_IO_WRITE
    } piopd_cycle_t;

endpackage : piopd_pkg

`default_nettype wire

/* File: src/piopd_latch.sv */
`default_nettype none

module piopd_latch #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk) begin
        if (clear) begin
            q_reg <= RESET_VALUE;
        end else if (load) begin
            q_reg <= d;
        end
    end

    assign q = q_reg;

endmodule : piopd_latch

`default_nettype wire

/* File: tb/piopd_checker.sv */
`default_nettype none
module piopd_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_in,
    input wire logic iorq,
    input wire logic mreq,
    input wire logic m1,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr_lo,
    input wire logic addr_a14,
    input wire logic addr_a15,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic bank_line_high,
    input wire logic rom_qualifier_t,
    input wire logic rom_qualifier_u,
    input wire logic [6:0] status_inputs_n,
    input wire logic [7:0] motor_drive_hi_n,
    input wire logic [7:0] motor_drive_lo_n,
    input wire logic disk_unit_select_n,
    input wire logic rom_select_n,
    input wire logic disk_unit_reset_n,
    input wire logic irq_n_oe
);
    wire io = iorq && !m1 && !(rd_n && wr_n);
    wire wr = io && !wr_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || reset_in);
    a_motor_hi_load:
        assert property (wr && addr_lo == 8'h83 |=> ##1 motor_drive_hi_n == ~$past(data_in, 2))
        else $error("upper motor load");
    a_motor_lo_load:
        assert property (wr && addr_lo == 8'h82 |=> ##1 motor_drive_lo_n == ~$past(data_in, 2))
        else $error("lower motor load");
    a_disk_reset_sw:
        assert property (wr && addr_lo == 8'h81 |=> disk_unit_reset_n == $past(data_in[0]))
        else $error("disk reset write");
    a_reset_values:
        assert property (disable iff (1'b0) rst || reset_in |=> motor_drive_hi_n == 8'hFF
            && motor_drive_lo_n == 8'hFF && !disk_unit_reset_n && !irq_n_oe && !data_oe)
        else $error("reset values");
    a_disk_sel_on:
        assert property (io && addr_lo[7:4] == 4'h7 |=> !disk_unit_select_n)
        else $error("disk select");
    a_disk_sel_off:
        assert property (!iorq |=> disk_unit_select_n)
        else $error("disk select without io");
    a_rom_sel_on:
        assert property (bank_line_high && mreq && rom_qualifier_t && !rom_qualifier_u
            && !addr_a15 && addr_a14 |=> !rom_select_n)
        else $error("rom select");
    a_status_read:
        assert property (io && !rd_n && wr_n && addr_lo == 8'h81
            |=> data_oe && data_out == {1'h0, ~$past(status_inputs_n)})
        else $error("status read");
    a_irq_quiet:
        assert property (&status_inputs_n |=> !irq_n_oe)
        else $error("irq without input");
    a_rom_sel_off:
        assert property (!mreq |=> rom_select_n)
        else $error("rom select without mreq");
    a_read_quiet:
        assert property (rd_n |=> !data_oe)
        else $error("bus driven without read");
endmodule : piopd_checker
bind piopd_top piopd_checker chk_u (.*);
`default_nettype wire

/* File: tb/piopd_host_model.sv */
`default_nettype none
module piopd_host_model (
    input wire logic clk,
    output logic iorq,
    output logic mreq,
    output logic m1,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] addr_lo,
    output logic addr_a14,
    output logic addr_a15,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {iorq, mreq, m1, addr_a14, addr_a15} = 5'h00;
        {rd_n, wr_n} = 2'h3;
        addr_lo = 8'h00;
        data_in = 8'h00;
    end
    // One bus cycle taken at the next edge, released bus flips
    task cyc(input logic io, input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        iorq <= io;
        mreq <= !io;
        wr_n <= !wr;
        rd_n <= wr;
        {addr_a15, addr_a14} <= a[15:14];
        addr_lo <= a[7:0];
        data_in <= wr ? d : ~data_in;
        @(posedge clk);
        {iorq, mreq} <= 2'h0;
        {rd_n, wr_n} <= 2'h3;
        data_in <= ~data_in;
    endtask : cyc
    // Interrupt acknowledge marker for the next cycles
    task set_m1(input logic v);
        m1 <= v;
    endtask : set_m1
endmodule : piopd_host_model
`default_nettype wire

/* File: tb/piopd_top_tb.sv */
`default_nettype none
module piopd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reset_in = 1'b0;
    logic bank_line_high = 1'b0;
    logic rom_qualifier_t = 1'b0;
    logic rom_qualifier_u = 1'b0;
    logic [6:0] status_inputs_n = 7'h7F;
    logic iorq, mreq, m1, rd_n, wr_n, addr_a14, addr_a15, data_oe, irq_n_out, irq_n_oe;
    logic disk_unit_select_n, rom_select_n, disk_unit_reset_n;
    logic [7:0] addr_lo, data_in, data_out, motor_drive_hi_n, motor_drive_lo_n;
    int n_mismatch = 0;
    int checks = 0;
    int ticks = 0;
    wire irq_line = irq_n_oe ? irq_n_out : 1'b1;
    piopd_host_model h_u (.*);
    piopd_top dut_u (.*);
    initial begin
        forever #4 clk = ~clk;
    end
    task finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    always @(posedge clk) begin
        ticks++;
        if (ticks == 2000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : at
    task automatic t_motor();
        logic [7:0] ph [8] = '{8'h01, 8'h03, 8'h02, 8'h06, 8'h04, 8'h0C, 8'h08, 8'h09};
        chk(motor_drive_hi_n, 8'hFF);
        chk({7'h00, irq_line}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            h_u.cyc(1'b1, 1'b1, 16'h0083, ph[i]);
            h_u.cyc(1'b1, 1'b1, 16'h0082, ~ph[i]);
            at(1);
            chk(motor_drive_hi_n, ~ph[i]);
            chk(motor_drive_lo_n, ph[i]);
        end
        h_u.cyc(1'b0, 1'b1, 16'h0083, 8'hF6);
        at(1);
        chk(motor_drive_hi_n, 8'hF6);
        h_u.cyc(1'b1, 1'b0, 16'h0083, 8'h00);
        #1;
        chk(data_out, 8'h09);
        chk({7'h00, data_oe}, 8'h01);
        at(1);
        chk({7'h00, data_oe}, 8'h00);
        $display("t_motor done");
    endtask : t_motor
    task t_irq();
        @(posedge clk);
        status_inputs_n <= 7'h5F;
        h_u.cyc(1'b1, 1'b0, 16'h0081, 8'h00);
        #1;
        chk(data_out, 8'h20);
        chk({7'h00, irq_line}, 8'h01);
        h_u.cyc(1'b1, 1'b1, 16'h0080, 8'h20);
        at(1);
        chk({7'h00, irq_line}, 8'h00);
        h_u.cyc(1'b1, 1'b1, 16'h0080, 8'h5F);
        at(1);
        chk({7'h00, irq_line}, 8'h01);
        h_u.cyc(1'b1, 1'b1, 16'h0080, 8'h7F);
        @(posedge clk);
        status_inputs_n <= 7'h7F;
        at(1);
        chk({7'h00, irq_line}, 8'h01);
        chk({7'h00, disk_unit_reset_n}, 8'h00);
        h_u.cyc(1'b1, 1'b1, 16'h0081, 8'h01);
        #1;
        chk({7'h00, disk_unit_reset_n}, 8'h01);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_sel();
        logic [7:0] a [4] = '{8'h6F, 8'h70, 8'h7F, 8'h80};
        logic [4:0] v;
        for (int i = 0; i < 4; i++) begin
            h_u.cyc(1'b1, 1'b0, {8'h00, a[i]}, 8'h00);
            #1;
            chk({7'h00, disk_unit_select_n}, {7'h00, i == 0 || i == 3});
            chk({7'h00, data_oe}, 8'h00);
        end
        for (int i = 0; i < 6; i++) begin
            v = 5'h19 ^ (5'h01 << i);
            @(posedge clk);
            {bank_line_high, rom_qualifier_t, rom_qualifier_u} <= v[4:2];
            h_u.cyc(1'b0, 1'b0, {v[1:0], 14'h0070}, 8'h00);
            #1;
            chk({7'h00, rom_select_n}, {7'h00, i != 5});
            chk({7'h00, disk_unit_select_n}, 8'h01);
        end
        h_u.cyc(1'b1, 1'b0, 16'h4070, 8'h00);
        #1;
        chk({7'h00, rom_select_n}, 8'h01);
        chk({7'h00, disk_unit_select_n}, 8'h00);
        h_u.set_m1(1'b1);
        h_u.cyc(1'b1, 1'b1, 16'h0070, 8'h00);
        #1;
        chk({7'h00, disk_unit_select_n}, 8'h01);
        h_u.cyc(1'b1, 1'b1, 16'h0083, 8'h00);
        h_u.set_m1(1'b0);
        at(1);
        chk(motor_drive_hi_n, 8'hF6);
        $display("t_sel done");
    endtask : t_sel
    task t_reset_in();
        @(posedge clk);
        reset_in <= 1'b1;
        @(posedge clk);
        reset_in <= 1'b0;
        #1;
        chk(motor_drive_hi_n, 8'hFF);
        chk({7'h00, disk_unit_reset_n}, 8'h00);
        $display("t_reset_in done");
    endtask : t_reset_in
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        at(1);
        t_motor();
        t_irq();
        t_sel();
        t_reset_in();
        finish_test();
    end
endmodule : piopd_top_tb
`default_nettype wire
